//--- logic/sfb_bank.sv
// sfb_bank: special-function flag and module-enable byte registers, axi4-lite slave
// assumes: event inputs are asynchronous levels; aresetn is the power-up clear,
// por_n the power-on reset (both synchronous, active low)
//
// Overview of operation
// [RL1] watchdog overflow or key violation sets watchdog flag; the code sets it on overflow only while wdog_mode is high
// [RL2] watchdog flag cleared only by power-on or pin reset; the code skips the pin-reset clear when an nmi event rises in the same cycle
// [RL3] oscillator fault sets oscillator fault flag
// [RL4] pin nmi event sets nmi flag
// [RL5] flag register two bit0: serial rx, rw-0
// [RL6] flag register two bit1: serial tx, rw-0
// [RL7] separate async receiver and transmitter enables
// [RL8] one enable for synchronous serial mode
// [RL9] plain resets on power-up clear, parenthesised on power-on
// [RL10] only documented flag and enable bits stored
// [RL11] bank decoded in byte range 0fh to 00h
// [RL12] unused bits read zero; writes set/clear flags
// [RL13] hardware set beats same-cycle software clear
`timescale 1ns/10ps
module sfb_bank
  import sfb_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        por_n,
  input  wire logic        wdog_overflow,
  input  wire logic        wdog_mode,
  input  wire logic        key_violation,
  input  wire logic        osc_fault,
  input  wire logic        nmi_event,
  input  wire logic        pin_reset,
  input  wire logic        serial_rx_event,
  input  wire logic        serial_tx_event,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             async_rx_enable,
  output logic             async_tx_enable,
  output logic             sync_serial_enable,
  output logic             irq
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [8:0] raw_in;
  logic [8:0] lvl;
  logic [8:0] rise;

  assign raw_in = {serial_tx_event, serial_rx_event, pin_reset, nmi_event,
                   osc_fault, key_violation, wdog_mode, wdog_overflow, 1'b0};

  genvar gi;
  generate
    for (gi = 1; gi < 9; gi++) begin : g_sync
      sfb_edge_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (raw_in[gi]),
        .level   (lvl[gi]),
        .rise    (rise[gi])
      );
    end
  endgenerate
  assign lvl[0]  = 1'b0;
  assign rise[0] = 1'b0;

  wire wdog_set  = (rise[1] & lvl[2]) | rise[3]; // [RL1]
  wire osc_set   = lvl[4];                       // [RL3]
  wire nmi_set   = rise[5];                      // [RL4]
  wire pin_rst   = rise[6];
  wire rx_set    = rise[7];
  wire tx_set    = rise[8];

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  logic        awready_reg;
  logic        wready_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [7:0]  wdata_reg;
  logic        wstrb0_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;

  // ready comes from a flop: offered the cycle after valid, dropped at the take
  wire aw_offer  = s_axi_awvalid & ~awready_reg & ~aw_held_reg & ~bvalid_reg;
  wire w_offer   = s_axi_wvalid & ~wready_reg & ~w_held_reg & ~bvalid_reg;
  wire aw_take   = s_axi_awvalid & awready_reg;
  wire w_take    = s_axi_wvalid & wready_reg;
  wire wr_fire   = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire wr_in_map = (awaddr_reg <= SFB_ADDR_TOP) | (awaddr_reg == SFB_ADDR_IRQ_ST)
                   | (awaddr_reg == SFB_ADDR_IRQ_MSK);
  wire wr_go     = wr_fire & wstrb0_reg;

  wire wr_flag1  = wr_go & (awaddr_reg == SFB_ADDR_FLAG1);
  wire wr_flag2  = wr_go & (awaddr_reg == SFB_ADDR_FLAG2);
  wire wr_en1    = wr_go & (awaddr_reg == SFB_ADDR_ENABLE1);
  wire wr_en2    = wr_go & (awaddr_reg == SFB_ADDR_ENABLE2);
  wire wr_ist    = wr_go & (awaddr_reg == SFB_ADDR_IRQ_ST);
  wire wr_imsk   = wr_go & (awaddr_reg == SFB_ADDR_IRQ_MSK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 8'h00;
      wstrb0_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= SFB_RESP_OK;
    end else begin
      awready_reg <= aw_offer;
      wready_reg  <= w_offer;
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= (s_axi_awaddr[31:8] == 24'h000000) ? s_axi_awaddr[7:0] : 8'hff;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_in_map ? SFB_RESP_OK : SFB_RESP_ERR; // [RL11]
      end else if (bvalid_reg & s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // ----------------------------------------------------------------
  // flag storage
  // ----------------------------------------------------------------
  // watchdog flag survives power-up clear; of the resets only power-on, or a pin reset with no same-cycle nmi event, clears it
  sfb_ev_if ev_wdog ();
  sfb_ev_if ev_osc ();
  sfb_ev_if ev_nmi ();
  sfb_ev_if ev_rx ();
  sfb_ev_if ev_tx ();

  assign ev_wdog.hw_set = wdog_set;
  assign ev_wdog.sw_wr  = wr_flag1;
  assign ev_wdog.sw_val = wdata_reg[SFB_F1_WDOG];
  assign ev_osc.hw_set  = osc_set;
  assign ev_osc.sw_wr   = wr_flag1;
  assign ev_osc.sw_val  = wdata_reg[SFB_F1_OSC];
  assign ev_nmi.hw_set  = nmi_set;
  assign ev_nmi.sw_wr   = wr_flag1;
  assign ev_nmi.sw_val  = wdata_reg[SFB_F1_NMI];
  assign ev_rx.hw_set   = rx_set;
  assign ev_rx.sw_wr    = wr_flag2;
  assign ev_rx.sw_val   = wdata_reg[SFB_F2_RX];
  assign ev_tx.hw_set   = tx_set;
  assign ev_tx.sw_wr    = wr_flag2;
  assign ev_tx.sw_val   = wdata_reg[SFB_F2_TX];

  wire clr_puc  = ~aresetn;                   // [RL9]
  wire clr_wdog = ~por_n | (pin_rst & ~nmi_set); // [RL2]

  sfb_flag_bit u_wdog (.aclk(aclk), .clr(clr_wdog), .ev(ev_wdog));
  sfb_flag_bit u_osc  (.aclk(aclk), .clr(~por_n),   .ev(ev_osc));
  sfb_flag_bit u_nmi  (.aclk(aclk), .clr(clr_puc),  .ev(ev_nmi));
  sfb_flag_bit u_rx   (.aclk(aclk), .clr(clr_puc),  .ev(ev_rx));  // [RL5]
  sfb_flag_bit u_tx   (.aclk(aclk), .clr(clr_puc),  .ev(ev_tx));  // [RL6]

  // ----------------------------------------------------------------
  // module enables and interrupt bank
  // ----------------------------------------------------------------
  logic arx_en_reg;
  logic atx_en_reg;
  logic sync_en_reg;
  logic [SFB_NUM_EV-1:0] ist_reg;
  logic [SFB_NUM_EV-1:0] imsk_reg;
  logic irq_reg;

  wire [SFB_NUM_EV-1:0] ev_vec = {tx_set, rx_set, nmi_set, osc_set, wdog_set};
  wire [SFB_NUM_EV-1:0] ist_next =
    ev_vec | (ist_reg & ~(wr_ist ? wdata_reg[SFB_NUM_EV-1:0] : 5'h00)); // [RL13]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arx_en_reg  <= 1'b0; // [RL9]
      atx_en_reg  <= 1'b0;
      sync_en_reg <= 1'b0;
      ist_reg     <= SFB_MASK_RST;
      imsk_reg    <= SFB_MASK_RST;
      irq_reg     <= 1'b0;
    end else begin
      if (wr_en1) begin
        arx_en_reg <= wdata_reg[SFB_E1_ARX]; // [RL7]
        atx_en_reg <= wdata_reg[SFB_E1_ATX]; // [RL7]
      end
      if (wr_en2) begin
        sync_en_reg <= wdata_reg[SFB_E1_SYNC]; // [RL8]
      end
      if (wr_imsk) begin
        imsk_reg <= wdata_reg[SFB_NUM_EV-1:0];
      end
      ist_reg <= ist_next;
      irq_reg <= |(ist_next & (wr_imsk ? wdata_reg[SFB_NUM_EV-1:0] : imsk_reg));
    end
  end

  assign async_rx_enable    = arx_en_reg;
  assign async_tx_enable    = atx_en_reg;
  assign sync_serial_enable = sync_en_reg;
  assign irq                = irq_reg;

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  // only stored bits appear; every other position reads zero
  logic        arready_reg;
  logic        rvalid_reg;
  logic [7:0]  rdata_reg;
  logic [1:0]  rresp_reg;

  wire        ar_offer = s_axi_arvalid & ~arready_reg & ~rvalid_reg;
  wire        ar_take  = s_axi_arvalid & arready_reg;
  wire [7:0]  ra      = (s_axi_araddr[31:8] == 24'h000000) ? s_axi_araddr[7:0] : 8'hff;
  wire [7:0]  rd_flag1 = {3'h0, ev_nmi.flag, 2'h0, ev_osc.flag, ev_wdog.flag}; // [RL10]
  wire [7:0]  rd_flag2 = {6'h00, ev_tx.flag, ev_rx.flag}; // [RL12]
  wire [7:0]  rd_en1   = {atx_en_reg, arx_en_reg, 6'h00};
  wire [7:0]  rd_en2   = {1'b0, sync_en_reg, 6'h00};
  wire        rd_map   = (ra <= SFB_ADDR_TOP) | (ra == SFB_ADDR_IRQ_ST)
                         | (ra == SFB_ADDR_IRQ_MSK); // [RL11]
  wire [7:0]  rd_mux   =
    (ra == SFB_ADDR_FLAG1)   ? rd_flag1 :
    (ra == SFB_ADDR_FLAG2)   ? rd_flag2 :
    (ra == SFB_ADDR_ENABLE1) ? rd_en1 :
    (ra == SFB_ADDR_ENABLE2) ? rd_en2 :
    (ra == SFB_ADDR_IRQ_ST)  ? {3'h0, ist_reg} :
    (ra == SFB_ADDR_IRQ_MSK) ? {3'h0, imsk_reg} : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 8'h00;
      rresp_reg   <= SFB_RESP_OK;
    end else begin
      arready_reg <= ar_offer;
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_mux;
        rresp_reg  <= rd_map ? SFB_RESP_OK : SFB_RESP_ERR;
      end else if (rvalid_reg & s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = {24'h000000, rdata_reg};
  assign s_axi_rresp   = rresp_reg;

endmodule

//--- logic/sfb_edge_sync.sv
// sfb_edge_sync: two-stage synchroniser with rising-edge pulse out
// assumes: input is asynchronous to aclk
`timescale 1ns/10ps
module sfb_edge_sync
  import sfb_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output logic      level,
  output logic      rise
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // --------------------------------
  // crossing
  // --------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~last_reg;

endmodule

//--- logic/sfb_flag_bit.sv
// sfb_flag_bit: one stored flag, set by hardware, written by software
// assumes: caller supplies the clear condition for its reset class
`timescale 1ns/10ps
module sfb_flag_bit
  import sfb_pkg::*;
(
  input  wire logic aclk,
  input  wire logic clr,
  sfb_ev_if.bit_side ev
);

  logic flag_reg;

  // --------------------------------
  // storage
  // --------------------------------
  always_ff @(posedge aclk) begin
    if (clr) begin
      flag_reg <= SFB_FLAG_RST;
    end else if (ev.hw_set) begin
      flag_reg <= 1'b1; // [RL13]
    end else if (ev.sw_wr) begin
      flag_reg <= ev.sw_val; // [RL12]
    end
  end

  assign ev.flag = flag_reg;

endmodule

//--- pkg/sfb_ev_if.sv
// sfb_ev_if: carries per-flag hardware set and software write strobes
// assumes: one clock; strobes are one-cycle pulses, except hw_set of the oscillator flag, which is a level
`timescale 1ns/10ps
interface sfb_ev_if;
  logic hw_set;
  logic sw_wr;
  logic sw_val;
  logic flag;
  modport ctl (output hw_set, output sw_wr, output sw_val, input flag);
  modport bit_side (input hw_set, input sw_wr, input sw_val, output flag);
endinterface

//--- pkg/sfb_pkg.sv
// sfb_pkg: constants and types for the special-function flag and enable bank
// assumes: byte registers mapped one per aligned 32-bit word on an axi4-lite slave
package sfb_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  // byte offsets of the bank are register indices; the bus address is index times four
  // irq status and mask sit just above the bank
  localparam int         SFB_IDX_FLAG1    = 2;
  localparam int         SFB_IDX_FLAG2    = 3;
  localparam int         SFB_IDX_ENABLE1  = 4;
  localparam int         SFB_IDX_ENABLE2  = 5;
  localparam int         SFB_IDX_TOP      = 15;
  localparam int         SFB_IDX_IRQ_ST   = 16;
  localparam int         SFB_IDX_IRQ_MSK  = 17;
  localparam logic [7:0] SFB_ADDR_FLAG1   = 8'(SFB_IDX_FLAG1 * 4);
  localparam logic [7:0] SFB_ADDR_FLAG2   = 8'(SFB_IDX_FLAG2 * 4);
  localparam logic [7:0] SFB_ADDR_ENABLE1 = 8'(SFB_IDX_ENABLE1 * 4);
  localparam logic [7:0] SFB_ADDR_ENABLE2 = 8'(SFB_IDX_ENABLE2 * 4);
  localparam logic [7:0] SFB_ADDR_IRQ_ST  = 8'(SFB_IDX_IRQ_ST * 4);
  localparam logic [7:0] SFB_ADDR_IRQ_MSK = 8'(SFB_IDX_IRQ_MSK * 4);
  localparam logic [7:0] SFB_ADDR_TOP     = 8'(SFB_IDX_TOP * 4 + 3);
  localparam logic [7:0] SFB_ADDR_DEC_TOP = 8'h4f;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SFB_F1_WDOG   = 0;
  localparam int SFB_F1_OSC    = 1;
  localparam int SFB_F1_NMI    = 4;
  localparam int SFB_F2_RX     = 0;
  localparam int SFB_F2_TX     = 1;
  localparam int SFB_E1_ARX    = 6;
  localparam int SFB_E1_ATX    = 7;
  localparam int SFB_E1_SYNC   = 6;
  localparam int SFB_NUM_EV    = 5;

  // ----------------------------------------------------------------
  // reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic       SFB_FLAG_RST = 1'b0;
  localparam logic [4:0] SFB_MASK_RST = 5'h00;
  localparam logic [1:0] SFB_RESP_OK  = 2'h0;
  localparam logic [1:0] SFB_RESP_ERR = 2'h2;

  typedef enum logic [0:0] {
    SFB_IDLE,
    SFB_RESP
  } sfb_bus_state_t;

endpackage

//--- tb/sfb_bank_chk.sv
// sfb_bank_chk: bus and enable assertions for sfb_bank
// assumes: bound onto sfb_bank, one clock, addresses below 0x100
`timescale 1ns/10ps
module sfb_bank_chk
  import sfb_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        async_rx_enable,
  input wire logic        async_tx_enable,
  input wire logic        sync_serial_enable
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_take(logic [7:0] a);
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr[7:0] == a && s_axi_wstrb[0];
  endsequence
  property en_upd(logic [7:0] a, int b, logic o);
    wr_take(a) |-> ##2 o == $past(s_axi_wdata[b], 2);
  endproperty
  chk_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_rd_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("read data late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_unmapped_err: assert property (ar_take ##0 s_axi_araddr[7:0] > SFB_ADDR_DEC_TOP
    |=> s_axi_rresp == SFB_RESP_ERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_en_rx: assert property (en_upd(SFB_ADDR_ENABLE1, SFB_E1_ARX, async_rx_enable))
    else $error("rx enable not written");
  chk_en_tx: assert property (en_upd(SFB_ADDR_ENABLE1, SFB_E1_ATX, async_tx_enable))
    else $error("tx enable not written");
  chk_en_sync: assert property (en_upd(SFB_ADDR_ENABLE2, SFB_E1_SYNC, sync_serial_enable))
    else $error("sync enable not written");
endmodule

//--- tb/sfb_bank_tb.sv
// sfb_bank_tb: self-checking bench for sfb_bank over axi4-lite
// assumes: sfb_ev_src drives the event pins, sfb_bank_chk is bound here
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sfb_bank_tb
  import sfb_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and tasks
  // ----------------------------------------------------------------
  logic        aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, wdog_mode = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [6:0]  fire_req = 7'h00;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, d;
  logic [3:0]  s;
  logic        async_rx_enable, async_tx_enable, sync_serial_enable, irq;
  logic [7:0]  shadow [3] = '{8'h00, 8'h00, 8'h00};
  wire  [6:0]  ev;
  int          error_cnt = 0, samples_checked = 0, cyc = 0, seed = 41049, k;
  localparam logic [7:0] RA [3] = '{SFB_ADDR_FLAG2, SFB_ADDR_ENABLE1, SFB_ADDR_ENABLE2};
  localparam logic [7:0] RST [6] = '{SFB_ADDR_FLAG1, SFB_ADDR_FLAG2, SFB_ADDR_ENABLE1,
                                     SFB_ADDR_ENABLE2, SFB_ADDR_IRQ_ST, SFB_ADDR_IRQ_MSK};
  sfb_bank uut (.aclk, .aresetn, .por_n, .wdog_overflow(ev[0]), .wdog_mode,
    .key_violation(ev[1]), .osc_fault(ev[2]), .nmi_event(ev[3]), .pin_reset(ev[4]),
    .serial_rx_event(ev[5]), .serial_tx_event(ev[6]), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .async_rx_enable,
    .async_tx_enable, .sync_serial_enable, .irq);
  sfb_ev_src src (.aclk, .fire(fire_req), .lines(ev));
  initial forever #2 aclk = ~aclk;
  function automatic logic [7:0] exp_val(input int i, input logic [31:0] v);
    return v[7:0] & (i == 0 ? 8'h03 : i == 1 ? 8'hc0 : 8'h40);
  endfunction
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= v;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) begin ad = 1'b1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wready === 1'b1) begin wd = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, e)
    `CHK(s_axi_rresp, er)
  endtask
  task automatic fire(input int i);
    @(posedge aclk);
    fire_req <= 7'h01 << i;
    @(posedge aclk);
    fire_req <= 7'h00;
    repeat (8) @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin error_cnt++; complete_run(); end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    foreach (RST[i]) rc(RST[i], 32'h0, SFB_RESP_OK);
    `CHK(irq, 1'b0)
    $display("test reset done");
    fire(0);
    rc(SFB_ADDR_FLAG1, 32'h00, SFB_RESP_OK);
    wdog_mode <= 1'b1;
    for (int i = 0; i < 7; i++) if (i != 1 && i != 4) fire(i);
    rc(SFB_ADDR_FLAG1, 32'h13, SFB_RESP_OK);
    rc(SFB_ADDR_FLAG2, 32'h03, SFB_RESP_OK);
    rc(SFB_ADDR_IRQ_ST, 32'h1f, SFB_RESP_OK);
    `CHK(irq, 1'b0)
    wr(SFB_ADDR_IRQ_MSK, 32'h04, 4'h1);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(SFB_ADDR_IRQ_ST, 32'h04, 4'h1);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b0)
    rc(SFB_ADDR_IRQ_ST, 32'h1b, SFB_RESP_OK);
    // oscillator fault held high: software clears must lose to the standing set
    fire_req <= 7'h04;
    repeat (6) @(posedge aclk);
    wr(SFB_ADDR_FLAG1, 32'h11, 4'h1);
    wr(SFB_ADDR_IRQ_ST, 32'h02, 4'h1);
    rc(SFB_ADDR_FLAG1, 32'h13, SFB_RESP_OK);
    rc(SFB_ADDR_IRQ_ST, 32'h1b, SFB_RESP_OK);
    fire_req <= 7'h00;
    repeat (8) @(posedge aclk);
    $display("test events done");
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc(SFB_ADDR_FLAG1, 32'h03, SFB_RESP_OK);
    rc(SFB_ADDR_FLAG2, 32'h00, SFB_RESP_OK);
    `CHK(irq, 1'b0)
    fire(4);
    rc(SFB_ADDR_FLAG1, 32'h02, SFB_RESP_OK);
    fire(1);
    rc(SFB_ADDR_FLAG1, 32'h03, SFB_RESP_OK);
    rc(8'h3c, 32'h0, SFB_RESP_OK);
    rc(8'h80, 32'h0, SFB_RESP_ERR);
    wr(8'h80, 32'hff, 4'hf);
    `CHK(rsp, SFB_RESP_ERR)
    $display("test reset classes done");
    for (int i = 0; i < 16; i++) begin
      k = {$random(seed)} % 3;
      d = (i == 0) ? 32'hffffffff : $random(seed);
      s = (i == 0) ? 4'h1 : 4'($random(seed));
      wr(RA[k], d, s);
      `CHK(rsp, SFB_RESP_OK)
      if (s[0]) shadow[k] = exp_val(k, d);
      rc(RA[k], {24'h0, shadow[k]}, SFB_RESP_OK);
      `CHK({async_tx_enable, async_rx_enable}, shadow[1][7:6])
      `CHK(sync_serial_enable, shadow[2][6])
    end
    $display("test random writes done");
    complete_run();
  end
endmodule
bind sfb_bank sfb_bank_chk chk_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .async_rx_enable, .async_tx_enable, .sync_serial_enable);

//--- tb/sfb_ev_src.sv
// sfb_ev_src: event sources outside the bank (watchdog, clock, pin, serial)
// assumes: fire is a one-cycle request per line, or held high to keep a line at a standing level; one clock
`timescale 1ns/10ps
module sfb_ev_src (
  input  wire logic       aclk,
  input  wire logic [6:0] fire,
  output logic      [6:0] lines
);
  // ----------------------------------------------------------------
  // pulse stretch
  // ----------------------------------------------------------------
  // three cycles high so the bank's two-stage synchronisers see an edge
  logic [6:0] h1_reg = 7'h00;
  logic [6:0] h2_reg = 7'h00;
  logic [6:0] h3_reg = 7'h00;
  always_ff @(posedge aclk) begin
    h1_reg <= fire;
    h2_reg <= h1_reg;
    h3_reg <= h2_reg;
  end
  assign lines = h1_reg | h2_reg | h3_reg;
endmodule
